// File: pmcap_params.svh
`ifndef PMCAP_PARAMS_SVH
`define PMCAP_PARAMS_SVH

// Configuration offsets, relative to the capability base
`define PMCAP_OFS_ID_WORD 8'h00
`define PMCAP_OFS_CSR_WORD 8'h04

// Fixed capability word contents
`define PMCAP_CAPABILITY_IDENTIFIER_VAL 8'h01
`define PMCAP_NEXT_PTR_VAL 8'h00
`define PMCAP_WAKE_SUPPORT_VAL 5'h0C
`define PMCAP_D2_SUP_VAL 1'h1
`define PMCAP_D1_SUP_VAL 1'h0
`define PMCAP_AUX_CUR_VAL 3'h0
`define PMCAP_DSI_VAL 1'h0
`define PMCAP_CAP_RSVD_VAL 1'h0
`define PMCAP_WAKE_CLK_VAL 1'h0
`define PMCAP_VERSION_VAL 3'h2
`define PMCAP_BSE_VAL 8'h00

// Control/status field positions
`define PMCAP_WAKE_STATUS_BIT 15
`define PMCAP_DATA_SCALE_LSB 13
`define PMCAP_DATA_SELECT_LSB 9
`define PMCAP_WAKE_EN_BIT 8
`define PMCAP_PSTATE_LSB 0
`define PMCAP_DATA_BYTE_LSB 24

// Reset values
`define PMCAP_PSTATE_RST 2'h0
`define PMCAP_DATA_SEL_RST 4'h0
`define PMCAP_DATA_SCALE_RST 2'h0
`define PMCAP_WAKE_EN_RST 1'h0
`define PMCAP_WAKE_STATUS_RST 1'h0

// Forbidden scale code and number of data window entries
`define PMCAP_SCALE_ILLEGAL 2'h0
`define PMCAP_DATA_SEL_NUM 9

`endif

// File: pmcap_pkg.sv
package pmcap_pkg;

  // Power state codes of the two-bit select field
  typedef enum logic [1:0] {
    PMCAP_D0 = 2'b00,
    PMCAP_D1_FORBIDDEN = 2'b01,
    PMCAP_D2 = 2'b10,
    PMCAP_D3HOT = 2'b11
  } pmcap_pstate_type;

  // Writable and sticky part of the control/status word
  typedef struct packed {
    logic wake_status;
    logic [1:0] data_scale;
    logic [3:0] data_select;
    logic wake_enable;
    pmcap_pstate_type power_state_select;
  } pmcap_csr_type;

  // One configuration access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pmcap_cfg_req_type;

endpackage

// File: pmcap_data_window.sv
`timescale 1ns/1ps
`include "pmcap_params.svh"

module pmcap_data_window
  import pmcap_pkg::*;
#(
  parameter int SEL_NUM = `PMCAP_DATA_SEL_NUM,
  parameter logic [8*SEL_NUM-1:0] DATA_VALUES = '0
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] data_select,
  output logic [7:0] data_q
);

  logic [7:0] table_mem [SEL_NUM];

  // Table is fixed content; a parameter keeps it free of any file
  always_comb begin
    for (int i = 0; i < SEL_NUM; i++) begin
      table_mem[i] = DATA_VALUES[8*i +: 8];
    end
  end

  // Codes above the table read zero rather than wrap around
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= 8'h00;
    end else if (32'(data_select) < SEL_NUM) begin
      data_q <= table_mem[data_select];
    end else begin
      data_q <= 8'h00;
    end
  end

endmodule

// File: pmcap_regs.sv
// Behaviour
// R1 - Identifier byte always reads 01h.
// R2 - Next-pointer byte always reads 00h.
// R3 - Wake-support field bits 31:27 reads 0Ch: D2 and D3hot only.
// R4 - Bit 26 reads one (D2 supported), bit 25 zero (no D1).
// R5 - Auxiliary current bits 24:22 read 000b.
// R6 - Bit 19 reads zero: no clock needed to signal wake.
// R7 - Version bits 18:16 read 010b.
// R8 - Wake status bit 15 reads one while wake is asserted; resets zero.
// R9 - Wake enable bit 8 gates wake; clear means wake never asserted.
// R10 - Power state: 00b D0, 10b D2, 11b D3hot; reset 00b; 01b forbidden.
// R11 - Software clears wake enable, then writes one to wake status.
// R12 - Bridge extension byte reads 00h, bits 23 and 22 zero.
// R13 - Data select, reset zero, picks power or temperature entry.
// R14 - Data scale codes 1h..3h give units; software never writes 0h.
// R15 - Data byte 31:24 shows the entry chosen by data select.
// R16 - Packet or bus reset in D2/D3hot with enable raises wake.
// R17 - Write one to status, or clearing enable, drops wake.
// R18 - A forbidden power-state write keeps the old state.
`timescale 1ns/1ps
`include "pmcap_params.svh"

module pmcap_regs
  import pmcap_pkg::*;
#(
  parameter int SEL_NUM = `PMCAP_DATA_SEL_NUM,
  parameter logic [8*SEL_NUM-1:0] DATA_VALUES = '0
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input pmcap_cfg_req_type CFG_REQ,
  output logic CFG_ACK,
  output logic [31:0] CFG_RDATA,
  input wire logic PKT_RX_IN,
  input wire logic BUS_RESET_IN,
  output logic WAKE_N_O,
  output logic WAKE_N_OE,
  output pmcap_pstate_type POWER_STATE
);

  pmcap_csr_type csr_q;
  pmcap_csr_type csr_d;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] filt_q;
  logic [1:0] rise;
  logic sleeping;
  logic wake_evt;
  logic hit_id;
  logic hit_csr;
  logic wr_lo;
  logic wr_hi;
  logic status_clr;
  logic wake_oe_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] win_byte;
  logic [15:0] cap_word;

  // True when the access targets the given word, read or write alike
  function automatic logic word_hit(input pmcap_cfg_req_type req,
                                    input logic [7:0] ofs);
    word_hit = (req.addr == ofs);
  endfunction

  // A state from which the function may signal wake
  function automatic logic can_wake(input pmcap_pstate_type ps);
    can_wake = (ps == PMCAP_D2) || (ps == PMCAP_D3HOT);
  endfunction

  assign hit_id = word_hit(CFG_REQ, `PMCAP_OFS_ID_WORD);
  assign hit_csr = word_hit(CFG_REQ, `PMCAP_OFS_CSR_WORD);
  assign wr_lo = CFG_REQ.wr && hit_csr && CFG_REQ.be[0];
  assign wr_hi = CFG_REQ.wr && hit_csr && CFG_REQ.be[1];
  assign status_clr = wr_hi && CFG_REQ.wdata[`PMCAP_WAKE_STATUS_BIT];

  // Fixed capability bits, built once from the constants
  assign cap_word = {`PMCAP_WAKE_SUPPORT_VAL, // R3
                     `PMCAP_D2_SUP_VAL, `PMCAP_D1_SUP_VAL, // R4
                     `PMCAP_AUX_CUR_VAL, // R5
                     `PMCAP_DSI_VAL, `PMCAP_CAP_RSVD_VAL,
                     `PMCAP_WAKE_CLK_VAL, // R6
                     `PMCAP_VERSION_VAL}; // R7

  // Event pins come from the serial-bus side; three stages each
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
    end else begin
      sync1_q <= {BUS_RESET_IN, PKT_RX_IN};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A level change is accepted only once stages two and three agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      filt_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Rising edge of each filtered event, one cycle wide
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rise[i] = (sync2_q[i] == sync3_q[i]) && sync3_q[i] && !filt_q[i];
    end
  end

  assign sleeping = can_wake(csr_q.power_state_select);
  assign wake_evt = (|rise) && sleeping && csr_q.wake_enable; // R16

  // Next value of the control/status fields
  always_comb begin
    csr_d = csr_q;
    if (wr_lo) begin
      // Forbidden code is dropped so the state never becomes D1
      if (CFG_REQ.wdata[`PMCAP_PSTATE_LSB +: 2] != PMCAP_D1_FORBIDDEN) begin
        csr_d.power_state_select =
          pmcap_pstate_type'(CFG_REQ.wdata[`PMCAP_PSTATE_LSB +: 2]); // R10
      end // R18
    end
    if (wr_hi) begin
      csr_d.wake_enable = CFG_REQ.wdata[`PMCAP_WAKE_EN_BIT]; // R9
      csr_d.data_select = CFG_REQ.wdata[`PMCAP_DATA_SELECT_LSB +: 4]; // R13
      // Scale code zero has no meaning; keep the last legal one
      if (CFG_REQ.wdata[`PMCAP_DATA_SCALE_LSB +: 2] !=
          `PMCAP_SCALE_ILLEGAL) begin
        csr_d.data_scale = CFG_REQ.wdata[`PMCAP_DATA_SCALE_LSB +: 2]; // R14
      end
    end
    // A wake event in the clearing cycle is not lost: set beats clear
    if (wake_evt) begin
      csr_d.wake_status = 1'b1; // R16
    end else if (status_clr) begin
      csr_d.wake_status = 1'b0; // R17
    end
  end

  // Control/status storage
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      csr_q.wake_status <= `PMCAP_WAKE_STATUS_RST; // R8
      csr_q.data_scale <= `PMCAP_DATA_SCALE_RST;
      csr_q.data_select <= `PMCAP_DATA_SEL_RST; // R13
      csr_q.wake_enable <= `PMCAP_WAKE_EN_RST;
      csr_q.power_state_select <= pmcap_pstate_type'(`PMCAP_PSTATE_RST); // R10
    end else begin
      csr_q <= csr_d;
    end
  end

  // Wake pin follows status and enable; clearing either drops it
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wake_oe_q <= 1'b0;
    end else begin
      wake_oe_q <= csr_d.wake_status && csr_d.wake_enable; // R9 R17
    end
  end

  // Open-drain: only ever pulls low
  assign WAKE_N_O = 1'b0;
  assign WAKE_N_OE = wake_oe_q;
  assign POWER_STATE = csr_q.power_state_select;

  // Power and temperature table behind the data byte
  pmcap_data_window #(
    .SEL_NUM(SEL_NUM),
    .DATA_VALUES(DATA_VALUES)
  ) u_window (
    .clk(REF_CLK),
    .rst(RST),
    .data_select(csr_q.data_select),
    .data_q(win_byte)
  );

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_id) begin
      rdata_d = {cap_word, `PMCAP_NEXT_PTR_VAL, `PMCAP_CAPABILITY_IDENTIFIER_VAL}; // R1 R2
    end else if (hit_csr) begin
      rdata_d[`PMCAP_DATA_BYTE_LSB +: 8] = win_byte; // R15
      rdata_d[23:16] = `PMCAP_BSE_VAL; // R12
      rdata_d[`PMCAP_WAKE_STATUS_BIT] = csr_q.wake_status; // R8
      rdata_d[`PMCAP_DATA_SCALE_LSB +: 2] = csr_q.data_scale; // R14
      rdata_d[`PMCAP_DATA_SELECT_LSB +: 4] = csr_q.data_select;
      rdata_d[`PMCAP_WAKE_EN_BIT] = csr_q.wake_enable;
      rdata_d[`PMCAP_PSTATE_LSB +: 2] = csr_q.power_state_select;
    end
  end

  // Read data is held until the next read; ack marks each access
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= CFG_REQ.rd || CFG_REQ.wr;
      if (CFG_REQ.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign CFG_ACK = ack_q;
  assign CFG_RDATA = rdata_q;

  // Checks on the register behaviour
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  sequence rd_id_s;
    CFG_REQ.rd && hit_id;
  endsequence

  sequence rd_csr_s;
    CFG_REQ.rd && hit_csr;
  endsequence

  sequence evt_no_clr_s;
    wake_evt && !status_clr;
  endsequence

  id_byte_a: assert property (rd_id_s |=> CFG_ACK && // R1
    CFG_RDATA[7:0] == 8'h01)
    else $error("identifier byte wrong");

  next_ptr_a: assert property (rd_id_s |=> // R2
    CFG_RDATA[15:8] == 8'h00)
    else $error("next pointer not zero");

  wake_support_a: assert property (rd_id_s |=> // R3
    CFG_RDATA[31:27] == 5'h0C)
    else $error("wake support field wrong");

  sleep_support_a: assert property (rd_id_s |=> // R4
    CFG_RDATA[26] && !CFG_RDATA[25])
    else $error("sleep state support bits wrong");

  aux_clock_a: assert property (rd_id_s |=> // R5
    CFG_RDATA[24:22] == 3'h0 && !CFG_RDATA[19])
    else $error("aux current or clock bit wrong");

  pm_version_a: assert property (rd_id_s |=> // R7
    CFG_RDATA[18:16] == 3'h2 && !CFG_RDATA[19]) // R6
    else $error("version field wrong");

  status_shown_a: assert property (WAKE_N_OE |-> // R8
    csr_q.wake_status && csr_q.wake_enable) // R9
    else $error("wake asserted without status and enable");

  pstate_legal_a: assert property ( // R10
    csr_q.power_state_select != PMCAP_D1_FORBIDDEN)
    else $error("power state holds forbidden code");

  forbid_keep_a: assert property (wr_lo && // R18
    CFG_REQ.wdata[1:0] == 2'b01 |=> $stable(POWER_STATE))
    else $error("forbidden power state write took effect");

  bridge_ext_a: assert property (rd_csr_s |=> // R12
    CFG_RDATA[23:16] == 8'h00)
    else $error("bridge extension not zero");

  data_byte_a: assert property (rd_csr_s |=> // R15
    CFG_RDATA[31:24] == $past(win_byte))
    else $error("data byte does not follow select");

  wake_raise_a: assert property (evt_no_clr_s ##1 // R16
    csr_q.wake_enable |-> WAKE_N_OE && csr_q.wake_status)
    else $error("wake event did not raise wake");

  wake_clear_a: assert property (status_clr && !wake_evt |=> // R17
    !WAKE_N_OE && !csr_q.wake_status)
    else $error("wake not dropped by status clear");

  scale_keep_a: assert property (wr_hi && // R14
    CFG_REQ.wdata[14:13] == 2'h0 |=> $stable(csr_q.data_scale))
    else $error("scale code zero was stored");

  set_wins_a: assert property (wake_evt && status_clr |=> // R16
    csr_q.wake_status)
    else $error("status clear beat a wake event");

  pstate_write_a: assert property (wr_lo && // R10
    CFG_REQ.wdata[1:0] != 2'b01 |=>
    POWER_STATE == $past(CFG_REQ.wdata[1:0]))
    else $error("power state write not applied");

  select_write_a: assert property (wr_hi |=> // R13
    csr_q.data_select == $past(CFG_REQ.wdata[12:9]))
    else $error("data select write not applied");

  scale_write_a: assert property (wr_hi && // R14
    CFG_REQ.wdata[14:13] != 2'h0 |=>
    csr_q.data_scale == $past(CFG_REQ.wdata[14:13]))
    else $error("data scale write not applied");

endmodule

// File: pmcap_host_model.sv
`timescale 1ns/1ps

module pmcap_host_model
  import pmcap_pkg::*;
(
  input wire logic clk,
  output pmcap_cfg_req_type req,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  logic ack_seen;
  logic [31:0] rd_seen;

  // Idle bus at time zero
  initial begin
    req = '0;
    ack_seen = 1'b0;
    rd_seen = '0;
  end

  // One access per call, held through the taking edge and then released.
  // Released address, byte-enable and data lines show the inverse so stale values never pass for valid.
  task automatic access(input logic rd, input logic wr, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] wd);
    @(posedge clk);
    #1;
    req = '{rd: rd, wr: wr, addr: a, be: be, wdata: wd};
    @(posedge clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~wd};
    ack_seen = ack;
    rd_seen = rdata;
  endtask
endmodule

// File: pci_power_mgmt_capability_tb.sv
`timescale 1ns/1ps

module pci_power_mgmt_capability_tb
  import pmcap_pkg::*;
;
  localparam logic [71:0] DV = 72'hA9_8877_6655_4433_2211;
  logic ref_clk, rst, pkt_rx, bus_rst, ack, w_o, w_oe;
  logic [31:0] rdata;
  pmcap_cfg_req_type req;
  pmcap_pstate_type pst;
  int error_cnt, cmp_count, cyc, seed, m_ps, m_sel, m_sc, m_en, m_st, i;

  pmcap_regs #(.DATA_VALUES(DV)) dut (.REF_CLK(ref_clk), .RST(rst),
    .CFG_REQ(req), .CFG_ACK(ack), .CFG_RDATA(rdata), .PKT_RX_IN(pkt_rx),
    .BUS_RESET_IN(bus_rst), .WAKE_N_O(w_o), .WAKE_N_OE(w_oe),
    .POWER_STATE(pst));
  pmcap_host_model host (.clk(ref_clk), .req(req), .ack(ack),
    .rdata(rdata));

  // Free-running 100 MHz clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // Hang guard, well above the length of the sequence
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reference word for each offset, built from the model fields
  function automatic logic [31:0] expect_word(input logic [7:0] a);
    logic [7:0] d;
    d = (m_sel < 9) ? DV[8*m_sel +: 8] : 8'h00;
    if (a == 8'h00)
      return {5'h0C, 1'b1, 1'b0, 3'h0, 3'h0, 3'h2, 8'h00, 8'h01};
    if (a == 8'h04)
      return {d, 8'h00, m_st[0], m_sc[1:0], m_sel[3:0], m_en[0], 6'h00,
        m_ps[1:0]};
    return 32'h0000_0000;
  endfunction

  task automatic rd(input logic [7:0] a);
    host.access(1'b1, 1'b0, a, 4'hF, 32'h0000_0000);
    check("ack", {31'h0, host.ack_seen}, 32'h1);
    check("rdata", host.rd_seen, expect_word(a));
  endtask

  // Control word write; forbidden codes leave the old field in place
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd);
    host.access(1'b0, 1'b1, a, be, wd);
    check("ack", {31'h0, host.ack_seen}, 32'h1);
    if (a == 8'h04 && be[0] && wd[1:0] != 2'h1)
      m_ps = wd[1:0];
    if (a == 8'h04 && be[1]) begin
      if (wd[14:13] != 2'h0)
        m_sc = wd[14:13];
      m_sel = wd[12:9];
      m_en = wd[8];
      if (wd[15])
        m_st = 0;
    end
    check("state", {30'h0, pst}, m_ps);
  endtask

  // Event pin pulse; wake must show four edges after the pin rises
  task automatic event_in(input bit bus, input bit exp);
    if (bus)
      bus_rst = 1'b1;
    else
      pkt_rx = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("wake_oe", {31'h0, w_oe}, exp);
    check("wake_o", {31'h0, w_o}, 32'h0);
    if (exp)
      m_st = 1;
    pkt_rx = 1'b0;
    bus_rst = 1'b0;
    rd(8'h04);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    seed = 35;
    rst = 1'b1;
    pkt_rx = 1'b0;
    bus_rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // Reset values, fixed words, ignored and unmapped places
    rd(8'h00);
    rd(8'h04);
    wr(8'h00, 4'hF, 32'hFFFF_FFFF);
    rd(8'h00);
    rd(8'h08);
    rd(8'hFC);
    $display("test reset done");
    // Wake setup: disable first, then clear status
    wr(8'h04, 4'h2, 32'h0000_0200);
    wr(8'h04, 4'h2, 32'h0000_8200);
    // Every power code, the forbidden one included
    for (i = 0; i < 4; i++) begin
      wr(8'h04, 4'h1, i);
      rd(8'h04);
    end
    $display("test power done");
    // Every select code with a random scale
    for (i = 0; i < 16; i++) begin
      wr(8'h04, 4'h2, {16'h0, 1'b0, 2'($random(seed)), 4'(i), 1'b0, 8'h00});
      rd(8'h04);
    end
    $display("test window done");
    // Wake: refused in D0, refused when disabled, then raised and dropped
    wr(8'h04, 4'h3, 32'h0000_0100);
    event_in(0, 0);
    wr(8'h04, 4'h3, 32'h0000_0002);
    event_in(1, 0);
    wr(8'h04, 4'h3, 32'h0000_0102);
    event_in(0, 1);
    wr(8'h04, 4'h2, 32'h0000_8100);
    @(posedge ref_clk);
    #1;
    check("wake_oe", {31'h0, w_oe}, 32'h0);
    wr(8'h04, 4'h1, 32'h0000_0003);
    event_in(1, 1);
    wr(8'h04, 4'h2, 32'h0000_0000);
    @(posedge ref_clk);
    #1;
    check("wake_oe", {31'h0, w_oe}, 32'h0);
    rd(8'h04);
    wr(8'h04, 4'h2, 32'h0000_8000);
    // Event and status clear taken at one edge: the event must win
    wr(8'h04, 4'h2, 32'h0000_0100);
    pkt_rx = 1'b1;
    repeat (2) @(posedge ref_clk);
    wr(8'h04, 4'h2, 32'h0000_8100);
    m_st = 1;
    check("wake_oe", {31'h0, w_oe}, 32'h1);
    pkt_rx = 1'b0;
    rd(8'h04);
    wr(8'h04, 4'h2, 32'h0000_8000);
    $display("test wake done");
    // Random control writes compared with the model
    for (i = 0; i < 40; i++) begin
      wr(8'h04, 4'($random(seed)), $random(seed));
      rd(8'h04);
    end
    $display("test random done");
    conclude();
  end
endmodule
